/* File: rtl/mtpo_pkg.sv */
package mtpo_pkg;
   // Divider sequencing for the amplitude scale
   typedef enum logic [0:0] {
      DIV_IDLE = 1'b0,
      DIV_RUN = 1'b1
   } mtpo_div_state_e;
   // Position inside the extended 1024-entry wave
   typedef logic [9:0] mtpo_microstep_counter_t;
   // Scale in units of 2^-17, 0.5 is full
   typedef logic [16:0] mtpo_scale_t;
endpackage : mtpo_pkg

/* File: rtl/mtpo_pwm_channel.sv */
`timescale 1ns/10ps
// ----------------------------------------
// One coil PWM comparator
// ----------------------------------------
module mtpo_pwm_channel
   import mtpo_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   mtpo_pwm_if.chan pif,
   input wire logic [7:0] mag,
   input wire logic neg,
   output logic pwm
);
   logic [15:0] thr_reg; // Threshold of the running period
   wire [40:0] prod; // period * scale * magnitude
   wire [15:0] delta; // Excursion from half period
   wire [15:0] half; // Half period, duty 0.5
   wire [15:0] thr_next; // Threshold for next period

   // Excursion never exceeds half, so duty holds in 0.5 +/- scale
   assign prod = 41'(pif.period) * 41'(pif.scale) * 41'(mag);
   assign delta = prod[40:25];
   assign half = {1'b0, pif.period[15:1]};
   assign thr_next = neg ? half - delta : half + delta;

   // Threshold only changes at the period boundary
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         thr_reg <= 16'h0000;
      else if (pif.wrap)
         thr_reg <= thr_next;
   end

   // Output high while counter below threshold
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pwm <= 1'b0;
      else
         pwm <= (pif.count < thr_reg);
   end
endmodule : mtpo_pwm_channel

/* File: rtl/mtpo_pwm_if.sv */
`timescale 1ns/10ps
// Shared timing of both coil channels
interface mtpo_pwm_if;
   logic [15:0] period; // Clock cycles per PWM period
   logic [16:0] scale; // Amplitude scale, 2^-17 units
   logic [15:0] count; // Free running period counter
   logic wrap; // Last cycle of the period
   modport src (output period, output scale, output count, output wrap);
   modport chan (input period, input scale, input count, input wrap);
endinterface : mtpo_pwm_if

/* File: rtl/mtpo_regs.svh */
`ifndef MTPO_REGS_SVH
`define MTPO_REGS_SVH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define MTPO_IDX_GLOBAL 8'h00
`define MTPO_IDX_AMPL 8'h05
`define MTPO_IDX_RES 8'h0A
`define MTPO_IDX_VMAX 8'h17
`define MTPO_IDX_PERIOD 8'h1F
`define MTPO_IDX_STATUS 8'h6A
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MTPO_PWM_EN_BIT 21
`define MTPO_REVERSE_BIT 28
`define MTPO_SCALE_EN_BIT 8
`define MTPO_AMPL_LSB 16
`define MTPO_AMPL_MSB 31
`define MTPO_RES_MAX 4'h8
// ----------------------------------------
// Reset values and arithmetic constants
// ----------------------------------------
`define MTPO_GLOBAL_RST 32'h0000_0000
`define MTPO_AMPL_RST 32'h0000_0000
`define MTPO_RES_RST 4'h0
`define MTPO_VMAX_RST 32'h0000_0000
`define MTPO_PERIOD_RST 32'h0000_0100
`define MTPO_SCALE_HALF 17'h1_0000
`define MTPO_DIV_STEPS 6'h30
`endif

/* File: rtl/mtpo_sine_rom.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Quarter wave table, two read ports
// ----------------------------------------
module mtpo_sine_rom
   import mtpo_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] addr_a,
   input wire logic [7:0] addr_b,
   output logic [7:0] data_a,
   output logic [7:0] data_b
);
   // Default contents: parabolic quarter wave, x*(512-x)/256
   function automatic logic [7:0] wave(input logic [7:0] x);
      logic [17:0] p;
      p = 18'(x) * (18'h200 - 18'(x));
      return p[15:8];
   endfunction : wave

   // Registered read data on both ports
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         data_a <= 8'h00;
         data_b <= 8'h00;
      end
      else
      begin
         data_a <= wave(addr_a);
         data_b <= wave(addr_b);
      end
   end
endmodule : mtpo_sine_rom

/* File: rtl/mtpo_top.sv */
// Summary of operation
// - Positive velocity walks table forward, negative back
// - Reverse bit inverts walking direction
// - Table holds 256 entries per full step
// - Resolution code 0010 steps counter by four
// - Period register sets PWM length in clocks
// - PWM enable replaces step/direction on pins
// - Coil A from sine, coil B cosine
// - Scale enable ties amplitude to velocity
// - Zero velocity scale is (amplitude+1)/2^17
// - Scale rises linearly to 0.5 at full velocity
// - Duty bounded by 0.5 plus/minus scale
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "mtpo_regs.svh"
module mtpo_top
   import mtpo_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [31:0] actual_velocity,
   input wire logic step_pulse,
   output logic step_pin,
   output logic direction_pin,
   output logic coil_a_output,
   output logic coil_b_output
);
   // ----------------------------------------
   // Register bus decode
   // ----------------------------------------
   logic [31:0] global_setup_reg; // Direction and output select
   logic [31:0] amplitude_setup_reg; // Scale enable, zero amplitude
   logic [31:0] full_scale_velocity_reg; // Velocity of full scale
   logic [31:0] pwm_period_cycles_reg; // PWM period in clocks
   logic [3:0] microstep_resolution_reg; // Resolution code

   // Word index match, used for read and write decode
   function automatic logic hit(input logic [9:0] a, input logic [7:0] i);
      return a == {i, 2'b00};
   endfunction : hit

   // Merge write data under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (st[b])
            r[b*8 +: 8] = wd[b*8 +: 8];
      return r;
   endfunction : merge

   wire hit_global = hit(paddr, `MTPO_IDX_GLOBAL);
   wire hit_ampl = hit(paddr, `MTPO_IDX_AMPL);
   wire hit_res = hit(paddr, `MTPO_IDX_RES);
   wire hit_vmax = hit(paddr, `MTPO_IDX_VMAX);
   wire hit_period = hit(paddr, `MTPO_IDX_PERIOD);
   wire hit_status = hit(paddr, `MTPO_IDX_STATUS);
   wire hit_any = hit_global | hit_ampl | hit_res | hit_vmax | hit_period
                  | hit_status;
   // Setup phase seen, answer in the following access cycle
   wire setup_w = psel & ~penable;
   // Write commits only at the completing access edge
   wire wr_w = psel & penable & pready & pwrite & hit_any;

   mtpo_microstep_counter_t microstep_counter_reg; // Position in extended wave
   logic [31:0] rd_mux; // Read data selection
   assign rd_mux = hit_global ? global_setup_reg :
                   hit_ampl ? amplitude_setup_reg :
                   hit_res ? {28'h0, microstep_resolution_reg} :
                   hit_vmax ? full_scale_velocity_reg :
                   hit_period ? pwm_period_cycles_reg :
                   hit_status ? {22'h0, microstep_counter_reg} :
                   32'h0000_0000;

   // Bus answer: zero wait states, error on unmapped word
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup_w;
         pslverr <= setup_w & ~hit_any;
         prdata <= (setup_w & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         global_setup_reg <= `MTPO_GLOBAL_RST;
         amplitude_setup_reg <= `MTPO_AMPL_RST;
         full_scale_velocity_reg <= `MTPO_VMAX_RST;
         pwm_period_cycles_reg <= `MTPO_PERIOD_RST;
         microstep_resolution_reg <= `MTPO_RES_RST;
      end
      else if (wr_w)
      begin
         if (hit_global)
            global_setup_reg <= merge(global_setup_reg, pwdata, pstrb);
         if (hit_ampl)
            amplitude_setup_reg <= merge(amplitude_setup_reg, pwdata, pstrb);
         if (hit_vmax)
            full_scale_velocity_reg <= merge(full_scale_velocity_reg,
                                             pwdata, pstrb);
         if (hit_period)
            pwm_period_cycles_reg <= merge(pwm_period_cycles_reg,
                                           pwdata, pstrb);
         if (hit_res && pstrb[0])
            microstep_resolution_reg <= pwdata[3:0];
      end
   end

   // ----------------------------------------
   // Microstep sequencer
   // ----------------------------------------
   wire reverse_w = global_setup_reg[`MTPO_REVERSE_BIT];
   wire pwm_en_w = global_setup_reg[`MTPO_PWM_EN_BIT];
   // Backward when velocity negative, flipped by reverse bit
   wire backward_w = actual_velocity[31] ^ reverse_w;
   // Coarser codes than full step saturate at full step
   wire [3:0] res_w = (microstep_resolution_reg > `MTPO_RES_MAX) ?
                      `MTPO_RES_MAX : microstep_resolution_reg;
   // Code 0 moves 1 of 256 entries, code 2 moves 4
   wire [9:0] inc_w = 10'h001 << res_w;
   wire [9:0] microstep_counter_next = backward_w ? microstep_counter_reg - inc_w :
                           microstep_counter_reg + inc_w;

   // Counter moves one increment per internal step
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         microstep_counter_reg <= 10'h000;
      else if (step_pulse)
         microstep_counter_reg <= microstep_counter_next;
   end

   // ----------------------------------------
   // Quarter wave folding
   // ----------------------------------------
   // Cosine is the same wave a quarter turn ahead
   wire [9:0] cos_cnt = microstep_counter_reg + 10'h100;
   wire [7:0] sin_idx = microstep_counter_reg[8] ?
                        ~microstep_counter_reg[7:0] :
                        microstep_counter_reg[7:0];
   wire [7:0] cos_idx = cos_cnt[8] ? ~cos_cnt[7:0] : cos_cnt[7:0];
   logic sin_neg_reg; // Sign aligned with table output
   logic cos_neg_reg; // Sign aligned with table output
   wire [7:0] sin_mag; // Sine magnitude
   wire [7:0] cos_mag; // Cosine magnitude

   // Signs delayed to match the registered table read
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sin_neg_reg <= 1'b0;
         cos_neg_reg <= 1'b0;
      end
      else
      begin
         sin_neg_reg <= microstep_counter_reg[9];
         cos_neg_reg <= cos_cnt[9];
      end
   end

   mtpo_sine_rom u_rom (
      .clock(clock),
      .rst(rst),
      .addr_a(sin_idx),
      .addr_b(cos_idx),
      .data_a(sin_mag),
      .data_b(cos_mag)
   );

   // ----------------------------------------
   // Velocity dependent amplitude scale
   // ----------------------------------------
   // Sequential divide keeps area small; scale lags by ~50 clocks
   mtpo_div_state_e div_state_reg; // Divider state
   logic [5:0] div_cnt_reg; // Remaining quotient bits
   logic [47:0] div_num_reg; // Numerator, becomes quotient
   logic [32:0] div_rem_reg; // Partial remainder
   logic [31:0] div_den_reg; // Snapshot of full scale velocity
   logic [16:0] div_base_reg; // Snapshot of zero speed scale
   mtpo_scale_t scale_reg; // Scale used by both channels

   wire [31:0] abs_vel = actual_velocity[31] ? 32'(-actual_velocity) :
                         32'(actual_velocity);
   // Zero speed amplitude plus one, in 2^-17 units
   wire [16:0] base_w = 17'(amplitude_setup_reg[`MTPO_AMPL_MSB:
                                                `MTPO_AMPL_LSB]) + 17'h1;
   wire [16:0] span_w = `MTPO_SCALE_HALF - base_w;
   wire sat_w = (abs_vel >= full_scale_velocity_reg);
   wire [32:0] rem_sh = {div_rem_reg[31:0], div_num_reg[47]};
   wire rem_ge = rem_sh >= {1'b0, div_den_reg};
   wire [16:0] lin_w = div_base_reg + div_num_reg[16:0];

   // Divider: (0.5 - base) * |v| / vmax, then added to base
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         div_state_reg <= DIV_IDLE;
         div_cnt_reg <= 6'h00;
         div_num_reg <= 48'h0;
         div_rem_reg <= 33'h0;
         div_den_reg <= 32'h0;
         div_base_reg <= 17'h0;
         scale_reg <= `MTPO_SCALE_HALF;
      end
      else
      begin
         case (div_state_reg)
            DIV_IDLE:
            begin
               div_base_reg <= base_w;
               div_den_reg <= full_scale_velocity_reg;
               div_num_reg <= 48'(span_w) * 48'(abs_vel);
               div_rem_reg <= 33'h0;
               div_cnt_reg <= `MTPO_DIV_STEPS;
               // Scaling off or full scale reached, no divide needed
               if (!amplitude_setup_reg[`MTPO_SCALE_EN_BIT] || sat_w)
                  scale_reg <= `MTPO_SCALE_HALF;
               else
                  div_state_reg <= DIV_RUN;
            end
            DIV_RUN:
            begin
               div_rem_reg <= rem_ge ? rem_sh - {1'b0, div_den_reg} :
                              rem_sh;
               div_num_reg <= {div_num_reg[46:0], rem_ge};
               div_cnt_reg <= div_cnt_reg - 6'h01;
               if (div_cnt_reg == 6'h01)
                  div_state_reg <= DIV_IDLE;
            end
            default:
               div_state_reg <= DIV_IDLE;
         endcase
         // Quotient complete: linear from base to 0.5
         if (div_state_reg == DIV_IDLE && div_cnt_reg == 6'h00 &&
             div_den_reg != 32'h0)
            scale_reg <= lin_w;
      end
   end

   // ----------------------------------------
   // PWM period counter and channels
   // ----------------------------------------
   mtpo_pwm_if pif ();
   logic [15:0] pwm_cnt_reg; // Position in PWM period
   wire [15:0] period_w = pwm_period_cycles_reg[15:0];
   // Period of 0 or 1 wraps every cycle
   wire wrap_w = (pwm_cnt_reg >= period_w - 16'h0001) ||
                 (period_w == 16'h0000);

   assign pif.period = period_w;
   assign pif.scale = scale_reg;
   assign pif.count = pwm_cnt_reg;
   assign pif.wrap = wrap_w;

   // Free running counter, one PWM period per wrap
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         pwm_cnt_reg <= 16'h0000;
      else
         pwm_cnt_reg <= wrap_w ? 16'h0000 : pwm_cnt_reg + 16'h0001;
   end

   wire [1:0] chan_pwm; // Raw channel outputs, A then B
   wire [7:0] chan_mag [2]; // Per channel magnitude
   wire chan_neg [2]; // Per channel sign
   assign chan_mag[0] = sin_mag;
   assign chan_mag[1] = cos_mag;
   assign chan_neg[0] = sin_neg_reg;
   assign chan_neg[1] = cos_neg_reg;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_chan
         mtpo_pwm_channel u_chan (
            .clock(clock),
            .rst(rst),
            .pif(pif.chan),
            .mag(chan_mag[g]),
            .neg(chan_neg[g]),
            .pwm(chan_pwm[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Output pin select
   // ----------------------------------------
   // PWM replaces step/direction when enabled
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         step_pin <= 1'b0;
         direction_pin <= 1'b0;
         coil_a_output <= 1'b0;
         coil_b_output <= 1'b0;
      end
      else
      begin
         step_pin <= pwm_en_w ? 1'b0 : step_pulse;
         direction_pin <= pwm_en_w ? 1'b0 : backward_w;
         coil_a_output <= pwm_en_w ? chan_pwm[0] : step_pulse;
         coil_b_output <= pwm_en_w ? chan_pwm[1] : backward_w;
      end
   end
endmodule : mtpo_top

/* File: tb/mtpo_stage_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Coil stage: averages each coil over 8 periods
// ----------------------------------------
module mtpo_stage_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic coil_a_output,
   input wire logic coil_b_output,
   input wire logic [15:0] period,
   output logic [15:0] high_a,
   output logic [15:0] high_b,
   output logic [15:0] rise_a
);
   logic [18:0] cnt_reg; // Position in window
   logic [15:0] ha_reg, hb_reg, ra_reg; // Running sums
   logic a_reg; // Last coil A level for edges
   // Phase free: any whole window of periods gives the duty
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg <= 19'h0_0000;
         {ha_reg, hb_reg, ra_reg} <= 48'h0;
         {high_a, high_b, rise_a} <= 48'h0;
         a_reg <= 1'b0;
      end
      else if (cnt_reg == {period, 3'h0} - 19'h0_0001)
      begin
         // Window closes: latch and restart
         high_a <= ha_reg + 16'(coil_a_output);
         high_b <= hb_reg + 16'(coil_b_output);
         rise_a <= ra_reg + 16'(coil_a_output && !a_reg);
         {ha_reg, hb_reg, ra_reg} <= 48'h0;
         cnt_reg <= 19'h0_0000;
         a_reg <= coil_a_output;
      end
      else
      begin
         ha_reg <= ha_reg + 16'(coil_a_output);
         hb_reg <= hb_reg + 16'(coil_b_output);
         ra_reg <= ra_reg + 16'(coil_a_output && !a_reg);
         cnt_reg <= cnt_reg + 19'h0_0001;
         a_reg <= coil_a_output;
      end
   end
endmodule : mtpo_stage_model

/* File: tb/mtpo_sva.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the PWM block
// ----------------------------------------
module mtpo_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic signed [31:0] actual_velocity,
   input wire logic step_pulse,
   input wire logic step_pin,
   input wire logic direction_pin,
   input wire logic coil_a_output,
   input wire logic coil_b_output
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic pwm_q; // Mirror of the PWM enable bit
   logic rev_q; // Mirror of the reverse bit
   logic commit; // Write to the setup word lands
   logic mapped; // Address hits a register
   assign commit = psel && penable && pready && pwrite && paddr == 10'h000;
   assign mapped = paddr inside {10'h000, 10'h014, 10'h028, 10'h05C,
      10'h07C, 10'h1A8};
   // Mirror updates on the same edge as the design's store
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pwm_q <= 1'b0;
         rev_q <= 1'b0;
      end
      else if (commit)
      begin
         // Strobed-off bytes keep their value
         if (pstrb[2])
            pwm_q <= pwdata[21];
         if (pstrb[3])
            rev_q <= pwdata[28];
      end
   end
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_err_decode: assert property (psel && !penable |=>
      pslverr == !$past(mapped))
      else $error("wrong error on decode");
   chk_err_zero_data: assert property (pslverr |-> prdata == 32'h0000_0000)
      else $error("data on refused read");
   chk_step_follow: assert property (
      !pwm_q |=> coil_a_output == $past(step_pulse) &&
      step_pin == $past(step_pulse))
      else $error("step output wrong");
   chk_dir_follow: assert property (
      !pwm_q |=> direction_pin == $past(actual_velocity[31] ^ rev_q) &&
      coil_b_output == direction_pin)
      else $error("direction output wrong");
   chk_pwm_pins_quiet: assert property (
      pwm_q |=> !step_pin && !direction_pin)
      else $error("step pins active in PWM mode");
   cover property (commit);
   cover property (!pwm_q && step_pulse);
   cover property (pwm_q && $rose(coil_b_output));
endmodule : mtpo_chk

bind mtpo_top mtpo_chk u_chk (
   .clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .actual_velocity(actual_velocity), .step_pulse(step_pulse),
   .step_pin(step_pin), .direction_pin(direction_pin),
   .coil_a_output(coil_a_output), .coil_b_output(coil_b_output)
);

/* File: tb/tb_microstep_table_pwm_output.sv */
`timescale 1ns/10ps
`define CK(g, e) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         num_errors++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
      end \
   end
module tb_microstep_table_pwm_output;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, step_pulse = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic signed [31:0] actual_velocity = 32'sh0000_0000;
   logic [31:0] prdata, rd, d;
   logic pready, pslverr, step_pin, direction_pin, er, rev;
   logic coil_a_output, coil_b_output;
   logic [15:0] high_a, high_b, rise_a;
   logic [9:0] cb;
   int num_errors = 0;
   int tests_run = 0;
   // Register map: address, reset value, used bits
   logic [9:0] ra[5] = '{10'h000, 10'h014, 10'h028, 10'h05C, 10'h07C};
   logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0100};
   logic [31:0] rm[5] = '{32'h1020_0000, 32'hFFFF_0100, 32'h0000_000F,
      32'hFFFF_FFFF, 32'h0000_FFFF};
   always #25 clock = ~clock;
   mtpo_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .actual_velocity(actual_velocity), .step_pulse(step_pulse),
      .step_pin(step_pin), .direction_pin(direction_pin),
      .coil_a_output(coil_a_output), .coil_b_output(coil_b_output));
   mtpo_stage_model u_stage (.clock(clock), .rst(rst),
      .coil_a_output(coil_a_output), .coil_b_output(coil_b_output),
      .period(16'h0040), .high_a(high_a), .high_b(high_b), .rise_a(rise_a));
   // ----------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------
   // One APB transfer; waits for ready as long as it takes
   task automatic apb(input logic [9:0] a, input logic w,
      input logic [31:0] wd, input logic [3:0] s);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      // Access phase lasts until ready; only the watchdog ends a hang
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Back to back step pulses
   task automatic step(input int n);
      @(posedge clock);
      step_pulse <= 1'b1;
      repeat (n) @(posedge clock);
      step_pulse <= 1'b0;
   endtask : step
   // Counter after n steps at a resolution code
   function automatic logic [9:0] next_cnt(logic [9:0] c, int code,
      logic back, int n);
      logic [9:0] dl;
      dl = 10'(10'h001 << ((code > 8) ? 8 : code)) * 10'(n);
      return back ? c - dl : c + dl;
   endfunction : next_cnt
   task results;
      $display("Errors %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   // Hang guard, several times the expected run
   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      results();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h6F16_1F60));
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         apb(ra[i], 1'b0, 32'h0, 4'hF);
         `CK(rd, rv[i])
      end
      // Only the top byte lands: reverse set, PWM off
      apb(10'h000, 1'b1, 32'hFFFF_FFFF, 4'h8);
      apb(10'h000, 1'b0, 32'h0, 4'hF);
      `CK(rd & rm[0], 32'h1000_0000)
      for (int i = 0; i < 5; i++)
      begin
         d = $urandom;
         apb(ra[i], 1'b1, d, 4'hF);
         apb(ra[i], 1'b0, 32'h0, 4'hF);
         `CK(rd & rm[i], d & rm[i])
      end
      // Unmapped word and read-only counter
      apb(10'h3FC, 1'b1, $urandom, 4'hF);
      `CK(er, 1'b1)
      apb(10'h3FC, 1'b0, 32'h0, 4'hF);
      `CK({er, rd}, {1'b1, 32'h0})
      apb(10'h1A8, 1'b0, 32'h0, 4'hF);
      d = rd;
      apb(10'h1A8, 1'b1, ~d, 4'hF);
      apb(10'h1A8, 1'b0, 32'h0, 4'hF);
      `CK(rd, d)
      // Resolution codes 0 to 9, random sign and reverse
      for (int c = 0; c < 10; c++)
      begin
         rev = 1'($urandom);
         apb(10'h028, 1'b1, 32'(c), 4'h1);
         apb(10'h000, 1'b1, {3'h0, rev, 28'h0}, 4'hF);
         actual_velocity <= $urandom;
         apb(10'h1A8, 1'b0, 32'h0, 4'hF);
         cb = rd[9:0];
         step(1 + c % 2);
         apb(10'h1A8, 1'b0, 32'h0, 4'hF);
         `CK(rd[9:0], next_cnt(cb, c, actual_velocity[31] ^ rev, 1 + c % 2))
      end
      // PWM at table start, scaling on at standstill
      actual_velocity <= 32'sh0000_0000;
      @(posedge clock);
      rst <= 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      apb(10'h07C, 1'b1, 32'h0000_0040, 4'hF);
      apb(10'h014, 1'b1, 32'h3FFF_0100, 4'hF);
      apb(10'h05C, 1'b1, 32'h0000_0100, 4'hF);
      apb(10'h000, 1'b1, 32'h0020_0000, 4'hF);
      repeat (1200) @(posedge clock);
      `CK(rise_a, 16'h0008)
      `CK(high_a, 16'h0100)
      `CK(high_b >= 16'h0130 && high_b <= 16'h0140, 1'b1)
      // Full scale velocity reaches full amplitude, scale 0.5
      actual_velocity <= 32'sh0000_0100;
      repeat (1200) @(posedge clock);
      `CK(high_b >= 16'h01E0, 1'b1)
      `CK(high_a, 16'h0100)
      // Half speed backwards: scale halfway from base to 0.5
      actual_velocity <= 32'shFFFF_FF80;
      repeat (1200) @(posedge clock);
      `CK(high_b >= 16'h0190 && high_b <= 16'h01A0, 1'b1)
      // Scaling off: full amplitude even at standstill
      actual_velocity <= 32'sh0000_0000;
      apb(10'h014, 1'b1, 32'h3FFF_0000, 4'hF);
      repeat (1200) @(posedge clock);
      `CK(high_b >= 16'h01E0, 1'b1)
      results();
   end
endmodule : tb_microstep_table_pwm_output
